// ==== logic/wake_cfg.svh ====
`ifndef WAKE_CFG_SVH
`define WAKE_CFG_SVH

// ==========================================================================
// register map (byte addresses)
`define ADDR_PORT_A      8'h00
`define ADDR_KEY_STATUS  8'h04
`define ADDR_KEY_ENABLE  8'h08
`define ADDR_CONFIG_TWO  8'h0c
`define ADDR_CONFIG_ONE  8'h10
`define ADDR_IRQ_STATUS  8'h14
`define ADDR_IRQ_MASK    8'h18

// ==========================================================================
// field positions
`define BIT_WAKE_LATCH   6
`define BIT_KEY_FLAG     3
`define BIT_KEY_ACK      2
`define BIT_KEY_MASK     1
`define BIT_WAKE_IE      6
`define BIT_RUN_IN_STOP  1
`define BIT_PERIOD_SEL   7
`define BIT_EV_OVERFLOW  0
`define BIT_EV_LATCHED   1

// ==========================================================================
// reset values
`define RST_CONFIG       8'h00
`define RST_IRQ          2'h0

// ==========================================================================
// timing counts (last count before wrap, in selected source cycles)
`define WAKE_SHORT_LAST  14'h01ff
`define WAKE_LONG_LAST   14'h3fff

`endif

// ==== logic/wake_pkg.sv ====
package wake_pkg;

  // counter sequencer, gray along idle -> count
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_COUNT = 2'b01
  } wake_state_e;

  typedef logic [13:0] wake_count_t;

  typedef struct packed {
    logic [2:0] sync;
    logic       stable;
  } sync_s;

  typedef struct packed {
    wake_state_e state;
    wake_count_t count;
    logic        request;
  } counter_s;

  typedef struct packed {
    logic        wake_latch;
    logic        wake_irq_enable;
    logic        key_irq_mask;
    logic [7:0]  config_one;
    logic [7:0]  config_two;
    logic        config_one_done;
    logic        config_two_done;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [31:0] prdata;
  } regs_s;

endpackage

// ==== logic/wake_edge_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// three-stage sampler, counts a rising edge once stages two and three agree
module wake_edge_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // sampled pin and result
  input  wire logic pin,
  output logic      rise
);

  wake_pkg::sync_s s_q;
  wake_pkg::sync_s s_d;

  // first stage feeds only the second, so metastability never reaches logic
  always_comb begin
    s_d      = s_q;
    s_d.sync = {s_q.sync[1:0], pin};
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.stable = s_q.sync[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise = s_d.stable & ~s_q.stable;

endmodule

`default_nettype wire

// ==== logic/wake_counter.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "wake_cfg.svh"

// ==========================================================================
// stop-mode period counter: counts ticks of the chosen source
module wake_counter (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // low-power mode state
  input  wire logic stop_mode,
  input  wire logic wait_mode,
  // source ticks and selection
  input  wire logic rc_tick,
  input  wire logic bus_tick,
  input  wire logic clock_run_in_stop,
  input  wire logic wake_period_select,
  // result
  output logic      wake_request,
  output logic      counting
);

  wake_pkg::counter_s c_q;
  wake_pkg::counter_s c_d;

  function automatic wake_pkg::wake_count_t last_count(input logic short_sel);
    last_count = short_sel ? `WAKE_SHORT_LAST : `WAKE_LONG_LAST;
  endfunction

  // sequencer and counter
  always_comb begin
    logic tick;
    tick        = 1'b0;
    c_d         = c_q;
    c_d.request = 1'b0;
    tick        = clock_run_in_stop ? bus_tick : rc_tick;
    unique case (c_q.state)
      wake_pkg::ST_IDLE: begin
        c_d.count = '0;
        if (stop_mode && !wait_mode) begin
          c_d.state = wake_pkg::ST_COUNT;
          c_d.count = '0;
        end
      end
      wake_pkg::ST_COUNT: begin
        if (!stop_mode || wait_mode) begin
          c_d.state = wake_pkg::ST_IDLE;
          c_d.count = '0;
        end else if (tick) begin
          if (c_q.count == last_count(wake_period_select)) begin
            c_d.count   = '0;
            c_d.request = 1'b1;
          end else begin
            c_d.count = c_q.count + 14'h0001;
          end
        end
      end
      default: begin
        c_d.state = wake_pkg::ST_IDLE;
        c_d.count = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_q <= '{state: wake_pkg::ST_IDLE, count: '0, request: 1'b0};
    end else begin
      c_q <= c_d;
    end
  end

  assign wake_request = c_q.request;
  assign counting     = (c_q.state == wake_pkg::ST_COUNT);

endmodule

`default_nettype wire

// ==== logic/auto_wakeup_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "wake_cfg.svh"

// ==========================================================================
// auto wakeup unit with its shared keyboard and config registers on apb
module auto_wakeup_unit (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // low-power mode state, same clock
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  // clock source pins, sampled
  input  wire logic        wake_rc_oscillator,
  input  wire logic        bus_clock_x4,
  // keyboard interrupt unit
  input  wire logic        key_pin_pending,
  output logic             key_ack_pulse,
  output logic             key_pending_flag,
  output logic             key_irq_request,
  output logic             wake_request,
  // status interrupt
  output logic             irq
);

  wake_pkg::regs_s r_q;
  wake_pkg::regs_s r_d;

  logic rc_tick;
  logic bus_tick;
  logic counting;

  // ========================================================================
  // source samplers and counter
  wake_edge_sync rc_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (wake_rc_oscillator),
    .rise    (rc_tick)
  );

  wake_edge_sync bus_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (bus_clock_x4),
    .rise    (bus_tick)
  );

  wake_counter counter (
    .pclk               (pclk),
    .presetn            (presetn),
    .stop_mode          (stop_mode),
    .wait_mode          (wait_mode),
    .rc_tick            (rc_tick),
    .bus_tick           (bus_tick),
    .clock_run_in_stop  (r_q.config_two[`BIT_RUN_IN_STOP]),
    .wake_period_select (r_q.config_one[`BIT_PERIOD_SEL]),
    .wake_request       (wake_request),
    .counting           (counting)
  );

  // ========================================================================
  // address decode, shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `ADDR_PORT_A) || (a == `ADDR_KEY_STATUS) ||
                (a == `ADDR_KEY_ENABLE) || (a == `ADDR_CONFIG_TWO) ||
                (a == `ADDR_CONFIG_ONE) || (a == `ADDR_IRQ_STATUS) ||
                (a == `ADDR_IRQ_MASK);
  endfunction

  // read mux; unmapped and reserved bits give zero
  function automatic logic [31:0] reg_read(input logic [7:0] a,
                                           input wake_pkg::regs_s r,
                                           input logic flag);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `ADDR_PORT_A:     v[`BIT_WAKE_LATCH] = r.wake_latch;
      `ADDR_KEY_STATUS: begin
        v[`BIT_KEY_FLAG] = flag;
        v[`BIT_KEY_MASK] = r.key_irq_mask;
      end
      `ADDR_KEY_ENABLE: v[`BIT_WAKE_IE] = r.wake_irq_enable;
      `ADDR_CONFIG_TWO: v = r.config_two;
      `ADDR_CONFIG_ONE: v = r.config_one;
      `ADDR_IRQ_STATUS: v[1:0] = r.irq_status;
      `ADDR_IRQ_MASK:   v[1:0] = r.irq_mask;
      default:          v = 8'h00;
    endcase
    reg_read = {24'h000000, v};
  endfunction

  logic setup;
  logic wr;
  logic ack_write;
  logic latch_set;
  logic [1:0] events;

  // ========================================================================
  // strobes: writes land only in the access phase
  always_comb begin
    setup     = psel & ~penable;
    wr        = psel & penable & pwrite & is_mapped(paddr);
    ack_write = wr & (paddr == `ADDR_KEY_STATUS) & pwdata[`BIT_KEY_ACK];
    latch_set = wake_request & r_q.wake_irq_enable;
    events    = {latch_set, wake_request};
  end

  // register next state
  always_comb begin
    r_d = r_q;
    // set wins over acknowledge so a same-cycle wakeup is not lost
    r_d.wake_latch = latch_set | (r_q.wake_latch & ~ack_write);
    if (wr && paddr == `ADDR_KEY_STATUS) begin
      r_d.key_irq_mask = pwdata[`BIT_KEY_MASK];
    end
    if (wr && paddr == `ADDR_KEY_ENABLE) begin
      r_d.wake_irq_enable = pwdata[`BIT_WAKE_IE];
    end
    // one-shot config: later writes are dropped silently
    if (wr && paddr == `ADDR_CONFIG_ONE && !r_q.config_one_done) begin
      r_d.config_one      = pwdata[7:0];
      r_d.config_one_done = 1'b1;
    end
    if (wr && paddr == `ADDR_CONFIG_TWO && !r_q.config_two_done) begin
      r_d.config_two      = pwdata[7:0];
      r_d.config_two_done = 1'b1;
    end
    // sticky status, write one to clear, new event wins
    if (wr && paddr == `ADDR_IRQ_STATUS) begin
      r_d.irq_status = events | (r_q.irq_status & ~pwdata[1:0]);
    end else begin
      r_d.irq_status = events | r_q.irq_status;
    end
    if (wr && paddr == `ADDR_IRQ_MASK) begin
      r_d.irq_mask = pwdata[1:0];
    end
    // read data captured in setup so prdata is a flop in the access phase
    if (setup) begin
      r_d.prdata = reg_read(paddr, r_q, key_pending_flag);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '{wake_latch:      1'b0,
               wake_irq_enable: 1'b0,
               key_irq_mask:    1'b0,
               config_one:      `RST_CONFIG,
               config_two:      `RST_CONFIG,
               config_one_done: 1'b0,
               config_two_done: 1'b0,
               irq_status:      `RST_IRQ,
               irq_mask:        `RST_IRQ,
               prdata:          32'h00000000};
    end else begin
      r_q <= r_d;
    end
  end

  // ========================================================================
  // outputs
  assign prdata           = r_q.prdata;
  assign pready           = 1'b1; // zero wait states
  assign pslverr          = psel & penable & ~is_mapped(paddr);
  assign key_ack_pulse    = ack_write;
  assign key_pending_flag = r_q.wake_latch | key_pin_pending;
  assign key_irq_request  = key_pending_flag & ~r_q.key_irq_mask;
  assign irq              = |(r_q.irq_status & r_q.irq_mask);

endmodule

`default_nettype wire

// ==== test/wake_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "wake_cfg.svh"

// ==========================================================================
// port-level checks for the auto wakeup unit
module wake_assertions (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // modes and keyboard side
  input wire logic        stop_mode,
  input wire logic        wait_mode,
  input wire logic        key_pin_pending,
  input wire logic        key_ack_pulse,
  input wire logic        key_pending_flag,
  input wire logic        key_irq_request,
  input wire logic        wake_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decode of mapped words and of an acknowledge write
  logic mapped;
  logic ack_wr;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `ADDR_IRQ_MASK);
  assign ack_wr = psel && penable && pwrite && paddr == `ADDR_KEY_STATUS && pwdata[`BIT_KEY_ACK];
  // ack not racing a fresh request, since a set wins over the clear
  sequence ack_alone;
    ack_wr && !wake_request;
  endsequence
  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_err_unmapped: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  chk_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  chk_req_single: assert property (wake_request |=> !wake_request)
    else $error("wake request longer than one cycle");
  chk_req_idle: assert property ((!$past(stop_mode) && !$past(stop_mode, 2))
    || ($past(wait_mode) && $past(wait_mode, 2)) |-> !wake_request)
    else $error("wake request outside stop");
  chk_pin_flag: assert property (key_pin_pending |-> key_pending_flag)
    else $error("flag low while key pending");
  chk_irq_flag: assert property (key_irq_request |-> key_pending_flag)
    else $error("irq request without pending flag");
  chk_ack_pulse: assert property (key_ack_pulse == ack_wr)
    else $error("ack pulse not tied to ack write");
  chk_ack_clears: assert property (ack_alone ##1 !key_pin_pending |-> !key_pending_flag)
    else $error("latch survived acknowledge");
endmodule

bind auto_wakeup_unit wake_assertions u_wake_assertions (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .stop_mode, .wait_mode, .key_pin_pending,
  .key_ack_pulse, .key_pending_flag, .key_irq_request, .wake_request);
`default_nettype wire

// ==== test/kb_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// keyboard side: a pin request that pends until acknowledged
module kb_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // press from the bench, acknowledge from the unit
  input wire logic press,
  input wire logic key_ack_pulse,
  output logic     key_pin_pending
);
  // a press in the ack cycle wins so no key event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_pin_pending <= 1'b0;
    end else if (press) begin
      key_pin_pending <= 1'b1;
    end else if (key_ack_pulse) begin
      key_pin_pending <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== test/auto_wakeup_unit_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "wake_cfg.svh"

// ==========================================================================
// self-checking bench for the auto wakeup unit
module auto_wakeup_unit_tb;
  logic        pclk, presetn, psel, penable, pwrite, stop_mode, wait_mode, press;
  logic        wake_rc_oscillator, bus_clock_x4, pready, pslverr, key_ack_pulse;
  logic        key_pending_flag, key_irq_request, wake_request, irq, key_pin_pending, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          failures, n_compared, n;

  auto_wakeup_unit u_auto_wakeup_unit (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .stop_mode, .wait_mode, .wake_rc_oscillator,
    .bus_clock_x4, .key_pin_pending, .key_ack_pulse, .key_pending_flag, .key_irq_request,
    .wake_request, .irq);
  kb_model u_kb_model (.pclk, .presetn, .press, .key_ack_pulse, .key_pin_pending);

  // 10 MHz clock
  always #50 pclk = ~pclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one apb transfer; the wait for pready is bounded, not assumed
  // pready and read data are taken at the rising edge that ends the access
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      failures++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  // toggle one source, 4 clocks per level; n is the rise count at the request, else 0
  task automatic run_src(input logic use_bus, input int lim);
    logic got;
    got = 1'b0;
    n = 0;
    while (!got && n < lim) begin
      n++;
      for (int k = 0; k < 8; k++) begin
        @(posedge pclk);
        if (use_bus) begin
          bus_clock_x4 <= (k < 4);
        end else begin
          wake_rc_oscillator <= (k < 4);
        end
        @(negedge pclk);
        if (wake_request === 1'b1) got = 1'b1;
      end
    end
    if (!got) n = 0;
  endtask

  task automatic t_reset();
    for (int a = 0; a <= 24; a += 4) rd_chk(8'(a), 32'h0);
    rd_chk(8'h1c, 32'h0);
    check(err, 1'b1);
  endtask

  task automatic t_long_idle();
    run_src(1'b0, 600);
    check(n, 0);
    @(posedge pclk);
    stop_mode <= 1'b1;
    run_src(1'b0, 600);
    check(n, 0);
    @(posedge pclk);
    stop_mode <= 1'b0;
  endtask

  task automatic t_short_rc();
    apb(1'b1, `ADDR_CONFIG_ONE, 32'h80);
    apb(1'b1, `ADDR_CONFIG_ONE, 32'h00);
    rd_chk(`ADDR_CONFIG_ONE, 32'h80);
    stop_mode <= 1'b1;
    run_src(1'b1, 600);
    check(n, 0);
    run_src(1'b0, 1000);
    check(n, 512);
    rd_chk(`ADDR_PORT_A, 32'h0);
    apb(1'b1, `ADDR_KEY_ENABLE, 32'h40);
    rd_chk(`ADDR_KEY_ENABLE, 32'h40);
    run_src(1'b0, 1000);
    check(n, 512);
    rd_chk(`ADDR_PORT_A, 32'h40);
    rd_chk(`ADDR_KEY_STATUS, 32'h08);
    @(negedge pclk);
    check(key_irq_request, 1'b1);
    @(posedge pclk);
    wait_mode <= 1'b1;
    run_src(1'b0, 600);
    check(n, 0);
    @(posedge pclk);
    wait_mode <= 1'b0;
    stop_mode <= 1'b0;
  endtask

  task automatic t_ack_mask();
    // outputs move at the edge that ends the write, so look half a cycle later
    apb(1'b1, `ADDR_KEY_STATUS, 32'h02);
    @(negedge pclk);
    check(key_irq_request, 1'b0);
    rd_chk(`ADDR_IRQ_STATUS, 32'h03);
    apb(1'b1, `ADDR_IRQ_MASK, 32'h03);
    @(negedge pclk);
    check(irq, 1'b1);
    apb(1'b1, `ADDR_IRQ_STATUS, 32'h03);
    @(negedge pclk);
    check(irq, 1'b0);
    apb(1'b1, `ADDR_KEY_STATUS, 32'h06);
    rd_chk(`ADDR_PORT_A, 32'h0);
    rd_chk(`ADDR_KEY_STATUS, 32'h02);
    @(posedge pclk);
    press <= 1'b1;
    @(posedge pclk);
    press <= 1'b0;
    @(negedge pclk);
    check({key_pending_flag, key_irq_request}, 2'b10);
    apb(1'b1, `ADDR_KEY_STATUS, 32'h04);
    @(negedge pclk);
    check(key_pending_flag, 1'b0);
  endtask

  task automatic t_bus_restart();
    apb(1'b1, `ADDR_CONFIG_TWO, 32'h02);
    apb(1'b1, `ADDR_CONFIG_TWO, 32'h00);
    rd_chk(`ADDR_CONFIG_TWO, 32'h02);
    stop_mode <= 1'b1;
    run_src(1'b1, 300);
    @(posedge pclk);
    stop_mode <= 1'b0;
    @(posedge pclk);
    stop_mode <= 1'b1;
    run_src(1'b1, 1000);
    check(n, 512);
    @(negedge pclk);
    check({key_pending_flag, key_irq_request}, 2'b11);
  endtask

  // reset held for 8 clocks, then the scenarios in order
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, stop_mode, wait_mode, press} = 6'h00;
    {wake_rc_oscillator, bus_clock_x4} = 2'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_long_idle();
    t_short_rc();
    t_ack_mask();
    t_bus_restart();
    finish_test();
  end
endmodule
`default_nettype wire
